// ---- verif/chain_partner.sv ----
`timescale 1ns/100ps
`default_nettype none
// --------
// Neighbour module on the shared lines; every line has a pull-down,
// so a line nobody drives high reads low rather than holding its value
// --------
module chain_partner (
    // Drivers of our module
    input  wire logic dp_or_drv_in, dp_or_oe_in, dp_nand_drv_in, dp_nand_oe_in,
    input  wire logic busy_or_drv_in, busy_or_oe_in, busy_nand_drv_in, busy_nand_oe_in,
    // Neighbour state
    input  wire logic nb_data_in, nb_busy_in,
    // Resolved lines
    output logic      dp_or_out, dp_nand_out, busy_or_out, busy_nand_out
);
    assign dp_or_out = (dp_or_oe_in & dp_or_drv_in) | nb_data_in;
    assign dp_nand_out = (dp_nand_oe_in & dp_nand_drv_in) | !nb_data_in;
    assign busy_or_out = (busy_or_oe_in & busy_or_drv_in) | nb_busy_in;
    assign busy_nand_out = (busy_nand_oe_in & busy_nand_drv_in) | !nb_busy_in;
endmodule // chain_partner
`default_nettype wire

// ---- verif/front_panel_checker.sv ----
`timescale 1ns/100ps
`default_nettype none
module front_panel_checker (
    input wire logic core_clk_in, reset_in, psel_in, penable_in, pready_out,
    input wire logic acq_window_in, common_window_in, conversion_inhibit_in,
    input wire logic front_reset_in, peak_clear_out, event_stored_out,
    input wire logic data_present_wired_or_out, data_present_wired_or_oe_out,
    input wire logic data_present_wired_nand_out, data_present_wired_nand_oe_out,
    input wire logic busy_wired_or_out, busy_wired_or_oe_out,
    input wire logic busy_wired_nand_out, busy_wired_nand_oe_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (reset_in);
    wire logic win = acq_window_in | common_window_in;
    wire logic bsy = busy_wired_or_oe_out;
    wire logic dpo = data_present_wired_or_oe_out;

    a_dp_split:
    assert property (dpo != data_present_wired_nand_oe_out) else $error("data enables clash");
    a_busy_split:
    assert property (bsy != busy_wired_nand_oe_out) else $error("busy enables clash");
    a_lines_high:
    assert property (!$past(reset_in) |-> data_present_wired_or_out && busy_wired_or_out
        && data_present_wired_nand_out && busy_wired_nand_out) else $error("line level low");
    a_window_busy:
    assert property ($rose(win) && !bsy && !conversion_inhibit_in |-> ##[2:6] bsy)
        else $error("window did not raise busy");
    a_store_clears:
    assert property (event_stored_out |-> peak_clear_out && $past(bsy))
        else $error("store without clear or conversion");
    a_store_ready:
    assert property (event_stored_out |=> ##[0:2] dpo) else $error("data present not driven");
    a_reset_clear:
    assert property ($rose(front_reset_in) |-> ##[2:6] peak_clear_out)
        else $error("front reset did not clear peaks");
    a_reset_busy:
    assert property ($rose(front_reset_in) |-> ##[3:8] bsy) else $error("no busy in reset");
    a_apb_answer:
    assert property (psel_in && !penable_in |=> pready_out ##1 !pready_out)
        else $error("bad ready pulse");

    c_store: cover property (event_stored_out);
    c_busy: cover property ($rose(bsy));
    c_clear_only: cover property (peak_clear_out && !event_stored_out);
endmodule // front_panel_checker

bind front_panel_control front_panel_checker u_chk (.*);
`default_nettype wire

// ---- verif/testbench.sv ----
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import front_panel_pkg::*;
    // --------
    // Named as the design ports so that .* joins them
    // --------
    logic        core_clk_in = 1'h0, reset_in = 1'h1, clk_en_in = 1'h1;
    logic        psel_in = 1'h0, penable_in = 1'h0, pwrite_in = 1'h0;
    logic [7:0]  paddr_in = 8'h00;
    logic [31:0] pwdata_in = 32'h0, prdata_out, rd;
    logic        pready_out, pslverr_out, peak_clear_out, event_stored_out, err;
    logic        acq_window_in = 1'h0, common_window_in = 1'h0, conversion_inhibit_in = 1'h0;
    logic        fast_abort_input_in = 1'h0, front_reset_in = 1'h0, nb_data = 1'h0, nb_busy = 1'h0;
    logic        data_present_wired_or_in, data_present_wired_or_out;
    logic        data_present_wired_or_oe_out, data_present_wired_nand_out;
    logic        data_present_wired_nand_oe_out, busy_wired_or_in, busy_wired_or_out;
    logic        busy_wired_or_oe_out, busy_wired_nand_out, busy_wired_nand_oe_out;
    logic        dp_nand, busy_nand;
    int          fails = 0, checked = 0, stores = 0, clears = 0;

    always #50 core_clk_in = ~core_clk_in;
    always @(posedge core_clk_in) if (event_stored_out === 1'h1) stores <= stores + 1;
    always @(posedge core_clk_in) if (peak_clear_out === 1'h1) clears <= clears + 1;

    front_panel_control DUT (.*);
    chain_partner neighbour (
        .dp_or_drv_in(data_present_wired_or_out), .dp_or_oe_in(data_present_wired_or_oe_out),
        .dp_nand_drv_in(data_present_wired_nand_out),
        .dp_nand_oe_in(data_present_wired_nand_oe_out),
        .busy_or_drv_in(busy_wired_or_out), .busy_or_oe_in(busy_wired_or_oe_out),
        .busy_nand_drv_in(busy_wired_nand_out), .busy_nand_oe_in(busy_wired_nand_oe_out),
        .nb_data_in(nb_data), .nb_busy_in(nb_busy), .dp_or_out(data_present_wired_or_in),
        .dp_nand_out(dp_nand), .busy_or_out(busy_wired_or_in), .busy_nand_out(busy_nand));

    task automatic end_sim;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk_in);
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge core_clk_in);
        psel_in <= 1'h1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge core_clk_in);
        penable_in <= 1'h1;
        for (n = 0; n < 8 && pready_out !== 1'h1; n++) @(posedge core_clk_in);
        if (n == 8) begin
            fails++;
            end_sim();
        end
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'h0;
        penable_in <= 1'h0;
    endtask

    // Window pulse on either input, then a fixed rest
    task automatic gate(input logic common, input int hold, input int rest);
        @(posedge core_clk_in);
        if (common) common_window_in <= 1'h1;
        else acq_window_in <= 1'h1;
        cyc(hold);
        acq_window_in <= 1'h0;
        common_window_in <= 1'h0;
        cyc(rest);
    endtask

    task automatic kick(input logic rst, input int pre);
        cyc(pre);
        if (rst) front_reset_in <= 1'h1;
        else fast_abort_input_in <= 1'h1;
        cyc(2);
        front_reset_in <= 1'h0;
        fast_abort_input_in <= 1'h0;
    endtask

    task automatic t_regs;
        apb(1'h0, CONTROL1_ADDR, 32'h0);
        check(rd, 32'h0, "control reset");
        apb(1'h0, ABORT_WIN_ADDR, 32'h0);
        check(rd, {24'h0, ABORT_WIN_RESET}, "window reset");
        apb(1'h1, ABORT_WIN_ADDR, 32'h8);
        apb(1'h0, ABORT_WIN_ADDR, 32'h0);
        check(rd, 32'h8, "window readback");
        apb(1'h1, 8'h40, 32'hffffffff);
        check(err, 32'h1, "unmapped error");
        apb(1'h0, STATUS1_ADDR, 32'h0);
        check(rd, 32'h0, "idle status");
        $display("regs done");
    endtask

    task automatic t_conv;
        stores = 0;
        gate(1'h1, 3, 5);
        apb(1'h0, STATUS1_ADDR, 32'h0);
        check(rd, 32'hc, "busy status");
        clk_en_in <= 1'h0;
        cyc(25);
        check(stores, 32'h0, "enable low freezes conversion");
        clk_en_in <= 1'h1;
        gate(1'h0, 3, 40);
        check(stores, 32'h1, "window while busy");
        apb(1'h0, STATUS1_ADDR, 32'h0);
        check(rd, 32'h3, "data status");
        check(dp_nand, 32'h1, "nand, neighbour empty");
        nb_data <= 1'h1;
        cyc(1);
        check(dp_nand, 32'h0, "nand, all hold data");
        apb(1'h1, RELEASE_ADDR, 32'h0);
        apb(1'h0, STATUS1_ADDR, 32'h0);
        check(rd, 32'h2, "neighbour line only");
        nb_data <= 1'h0;
        conversion_inhibit_in <= 1'h1;
        gate(1'h0, 5, 40);
        conversion_inhibit_in <= 1'h0;
        check(stores, 32'h1, "inhibited window");
        $display("conversion done");
    endtask

    task automatic t_abort;
        stores = 0;
        clears = 0;
        gate(1'h0, 3, 0);
        kick(1'h0, 1);
        gate(1'h0, 3, 40);
        check(stores, 32'h0, "aborted, early window");
        check(clears, 32'h1, "abort clears peaks");
        gate(1'h0, 3, 0);
        kick(1'h0, 14);
        cyc(30);
        check(stores, 32'h1, "late abort ignored");
        $display("abort done");
    endtask

    task automatic t_reset;
        apb(1'h0, EVT_COUNT_ADDR, 32'h0);
        check(rd, 32'h1, "one event held");
        kick(1'h1, 1);
        cyc(10);
        apb(1'h0, EVT_COUNT_ADDR, 32'h0);
        check(rd, 32'h0, "data reset empties");
        apb(1'h0, ABORT_WIN_ADDR, 32'h0);
        check(rd, 32'h8, "registers kept");
        apb(1'h1, CONTROL1_ADDR, 32'h10);
        stores = 0;
        gate(1'h0, 3, 5);
        kick(1'h1, 1);
        cyc(40);
        check(stores, 32'h0, "reset stops conversion");
        apb(1'h0, CONTROL1_ADDR, 32'h0);
        check(rd, 32'h0, "control cleared");
        apb(1'h0, ABORT_WIN_ADDR, 32'h0);
        check(rd, {24'h0, ABORT_WIN_RESET}, "window restored");
        $display("reset done");
    endtask

    task automatic t_busy;
        apb(1'h1, CONTROL1_ADDR, 32'h1);
        stores = 0;
        gate(1'h0, 3, 40);
        apb(1'h0, STATUS1_ADDR, 32'h0);
        check(rd, 32'hc, "memory test busy");
        check(stores, 32'h0, "window in memory test");
        apb(1'h1, CONTROL1_ADDR, 32'h0);
        nb_busy <= 1'h1;
        cyc(4);
        apb(1'h0, STATUS1_ADDR, 32'h0);
        check(rd, 32'h8, "neighbour busy");
        nb_busy <= 1'h0;
        for (int i = 0; i < 32; i++) gate(1'h0, 3, 36);
        apb(1'h0, STATUS1_ADDR, 32'h0);
        check(rd, 32'hf, "full buffer busy");
        nb_busy <= 1'h1;
        cyc(1);
        check(busy_nand, 32'h0, "nand, all busy");
        nb_busy <= 1'h0;
        apb(1'h1, RELEASE_ADDR, 32'h0);
        cyc(3);
        apb(1'h0, STATUS1_ADDR, 32'h0);
        check(rd, 32'h3, "release ends full");
        $display("busy done");
    endtask

    initial begin
        cyc(2);
        reset_in <= 1'h0;
        t_regs();
        t_conv();
        t_abort();
        t_reset();
        t_busy();
        end_sim();
    end
endmodule // testbench
`default_nettype wire

// ---- verilog/front_panel_control.sv ----
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/100ps
`default_nettype none

// Function
// - Fast abort honoured only inside the fast-abort window; otherwise ignored.
// - Accepted abort clears peak sections and discards the conversion entirely.
// - With reset scope set, front reset also restores control registers.
// - Data-present output while buffer holds an event; status bit 0.
// - Data-present lines: positive wired OR, negative wired NAND across modules.
// - Sampled positive data-present line shown in status bit 1.
// - Busy when converting, resetting, memory test or buffer full; status bit 2.
// - Busy lines: positive wired OR, negative wired NAND across modules.
// - Sampled positive busy line shown in status bit 3.
// - Inhibit during the window suppresses the store; conversion still runs and busy still rises, event not accepted.
// - Common window input ORed with connector window input.
// - Busy rises after window leading edge, falls at end; windows ignored while busy.
// - Abort window opens at window edge, lasts the programmed register duration.
// - Reset scope is control bit 4: 0 data reset, 1 also registers.
// - After abort, new window accepted only 600 ns after abort edge.
module front_panel_control (
    // Clock and reset
    input  wire logic                              core_clk_in,
    input  wire logic                              reset_in,
    input  wire logic                              clk_en_in,
    // APB slave
    input  wire logic                              psel_in,
    input  wire logic                              penable_in,
    input  wire logic                              pwrite_in,
    input  wire logic [front_panel_pkg::ADDR_W-1:0] paddr_in,
    input  wire logic [31:0]                       pwdata_in,
    output logic      [31:0]                       prdata_out,
    output logic                                   pready_out,
    output logic                                   pslverr_out,
    // Front-panel inputs
    input  wire logic                              acq_window_in,
    input  wire logic                              common_window_in,
    input  wire logic                              conversion_inhibit_in,
    input  wire logic                              fast_abort_input_in,
    input  wire logic                              front_reset_in,
    // Shared data-present lines
    input  wire logic                              data_present_wired_or_in,
    output logic                                   data_present_wired_or_out,
    output logic                                   data_present_wired_or_oe_out,
    output logic                                   data_present_wired_nand_out,
    output logic                                   data_present_wired_nand_oe_out,
    // Shared busy lines
    input  wire logic                              busy_wired_or_in,
    output logic                                   busy_wired_or_out,
    output logic                                   busy_wired_or_oe_out,
    output logic                                   busy_wired_nand_out,
    output logic                                   busy_wired_nand_oe_out,
    // Analog section control
    output logic                                   peak_clear_out,
    output logic                                   event_stored_out
);
    import front_panel_pkg::*;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [N_IN-1:0] raw_in;
    logic [N_IN-1:0] sync1;
    logic [N_IN-1:0] sync2;
    logic [N_IN-1:0] sync3;
    logic [N_IN-1:0] next_sync1;
    logic [N_IN-1:0] next_sync2;
    logic [N_IN-1:0] next_sync3;

    assign raw_in[IN_ACQ]       = acq_window_in;
    assign raw_in[IN_COMMON]    = common_window_in;
    assign raw_in[IN_INHIBIT]   = conversion_inhibit_in;
    assign raw_in[IN_ABORT]     = fast_abort_input_in;
    assign raw_in[IN_RESET]     = front_reset_in;
    assign raw_in[IN_DP_LINE]   = data_present_wired_or_in;
    assign raw_in[IN_BUSY_LINE] = busy_wired_or_in;
    generate
        for (genvar gi = 0; gi < N_IN; gi++) begin : g_sync
            always_comb begin
                next_sync1[gi] = clk_en_in ? raw_in[gi] : sync1[gi];
                next_sync2[gi] = clk_en_in ? sync1[gi] : sync2[gi];
                next_sync3[gi] = clk_en_in ? sync2[gi] : sync3[gi];
            end
            always_ff @(posedge core_clk_in or posedge reset_in) begin
                if (reset_in) begin
                    sync1[gi] <= 1'b0;
                    sync2[gi] <= 1'b0;
                    sync3[gi] <= 1'b0;
                end else begin
                    sync1[gi] <= next_sync1[gi];
                    sync2[gi] <= next_sync2[gi];
                    sync3[gi] <= next_sync3[gi];
                end
            end
        end
    endgenerate

    // Either window input opens capture
    logic window_level;
    logic window_edge;
    logic abort_edge;
    logic reset_edge;
    assign window_level = sync2[IN_ACQ] | sync2[IN_COMMON];
    assign window_edge  = window_level & ~(sync3[IN_ACQ] | sync3[IN_COMMON]);
    assign abort_edge   = sync2[IN_ABORT] & ~sync3[IN_ABORT];
    assign reset_edge   = sync2[IN_RESET] & ~sync3[IN_RESET];

    // ------------------------------------------------------------
    // Registers and APB
    // ------------------------------------------------------------
    conv_state_t      state;
    conv_state_t      next_state;
    logic [CR_W-1:0]  control1;
    logic [CR_W-1:0]  next_control1;
    logic [CNT_W-1:0] abort_win;
    logic [CNT_W-1:0] next_abort_win;
    logic [EVT_W-1:0] evt_count;
    logic [EVT_W-1:0] next_evt_count;
    logic [31:0]      next_prdata;
    logic             next_pready;
    logic             next_pslverr;
    logic             busy;
    logic             data_present;
    logic             evt_store;
    logic apb_setup;
    logic apb_write;
    logic mapped;
    assign apb_setup = psel_in & ~penable_in;
    assign apb_write = psel_in & penable_in & pready_out & pwrite_in;
    assign mapped    = (paddr_in == STATUS1_ADDR) | (paddr_in == CONTROL1_ADDR) |
                       (paddr_in == ABORT_WIN_ADDR) | (paddr_in == RELEASE_ADDR) |
                       (paddr_in == EVT_COUNT_ADDR);
    always_comb begin
        next_prdata    = prdata_out;
        next_pready    = 1'b0;
        next_pslverr   = 1'b0;
        next_control1  = control1;
        next_abort_win = abort_win;
        if (apb_setup) begin
            next_pready  = 1'b1;
            next_pslverr = ~mapped;
            next_prdata  = 32'h0000_0000;
            unique case (paddr_in)
                STATUS1_ADDR: begin
                    next_prdata[ST_DATA_PRESENT] = data_present;
                    next_prdata[ST_DP_LINE]      = sync2[IN_DP_LINE];
                    next_prdata[ST_BUSY]         = busy;
                    next_prdata[ST_BUSY_LINE]    = sync2[IN_BUSY_LINE];
                end
                CONTROL1_ADDR:  next_prdata[CR_W-1:0] = control1;
                ABORT_WIN_ADDR: next_prdata[CNT_W-1:0] = abort_win;
                EVT_COUNT_ADDR: next_prdata[EVT_W-1:0] = evt_count;
                default:        next_prdata = 32'h0000_0000;
            endcase
        end
        if (apb_write && paddr_in == CONTROL1_ADDR) begin
            next_control1 = pwdata_in[CR_W-1:0];
        end
        if (apb_write && paddr_in == ABORT_WIN_ADDR) begin
            next_abort_win = pwdata_in[CNT_W-1:0];
        end
        // Register scope reset overrides a write in the same cycle
        if (reset_edge && control1[CR_RESET_SCOPE]) begin
            next_control1  = CONTROL1_RESET;
            next_abort_win = ABORT_WIN_RESET;
        end
        if (!clk_en_in) begin
            next_prdata    = prdata_out;
            next_pready    = pready_out;
            next_pslverr   = pslverr_out;
            next_control1  = control1;
            next_abort_win = abort_win;
        end
    end

    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            prdata_out  <= 32'h0000_0000;
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
            control1    <= CONTROL1_RESET;
            abort_win   <= ABORT_WIN_RESET;
        end else begin
            prdata_out  <= next_prdata;
            pready_out  <= next_pready;
            pslverr_out <= next_pslverr;
            control1    <= next_control1;
            abort_win   <= next_abort_win;
        end
    end

    // ------------------------------------------------------------
    // Conversion sequencer
    // ------------------------------------------------------------
    logic [CNT_W-1:0] timer;
    logic [CNT_W-1:0] next_timer;
    logic [CNT_W-1:0] faw_count;
    logic [CNT_W-1:0] next_faw_count;
    logic             inhibit_seen;
    logic             next_inhibit_seen;
    logic             next_peak_clear;
    logic             start;
    logic             abort_ok;
    // Busy blocks new windows, so a full buffer can never be overrun
    assign busy         = (state != CONV_IDLE) | control1[CR_MEM_TEST] |
                          (evt_count == EVT_DEPTH);
    assign data_present = (evt_count != '0);
    assign start        = window_edge & ~busy;
    assign abort_ok     = abort_edge & (state == CONV_RUN) & (faw_count != '0);

    always_comb begin
        next_state        = state;
        next_timer        = timer;
        next_faw_count    = faw_count;
        next_inhibit_seen = inhibit_seen;
        next_peak_clear   = 1'b0;
        evt_store         = 1'b0;
        if (faw_count != '0) begin
            next_faw_count = faw_count - 1'b1;
        end
        unique case (state)
            CONV_IDLE: begin
                if (start) begin
                    next_state        = CONV_RUN;
                    next_timer        = CNT_W'(CONV_CYCLES - 1);
                    next_faw_count    = abort_win;
                    next_inhibit_seen = sync2[IN_INHIBIT];
                end
            end
            CONV_RUN: begin
                if (window_level && sync2[IN_INHIBIT]) begin
                    next_inhibit_seen = 1'b1;
                end
                if (abort_ok) begin
                    next_state      = CONV_CLEAR;
                    next_timer      = CNT_W'(ABORT_GAP_CYCLES - 1);
                    next_faw_count  = '0;
                    next_peak_clear = 1'b1;
                end else if (timer == '0) begin
                    next_state      = CONV_IDLE;
                    evt_store       = ~inhibit_seen;
                    next_peak_clear = 1'b1;
                end else begin
                    next_timer = timer - 1'b1;
                end
            end
            CONV_CLEAR: begin
                if (timer == '0) begin
                    next_state = CONV_IDLE;
                end else begin
                    next_timer = timer - 1'b1;
                end
            end
            default:    next_state = CONV_IDLE;
        endcase
        if (reset_edge) begin
            next_state      = CONV_CLEAR;
            next_timer      = CNT_W'(ABORT_GAP_CYCLES - 1);
            next_faw_count  = '0;
            next_peak_clear = 1'b1;
            evt_store       = 1'b0;
        end
        if (!clk_en_in) begin
            next_state        = state;
            next_timer        = timer;
            next_faw_count    = faw_count;
            next_inhibit_seen = inhibit_seen;
            next_peak_clear   = peak_clear_out;
            evt_store         = event_stored_out;
        end
    end

    // Occupancy: a store and a release in one cycle cancel out
    logic evt_release;
    assign evt_release = apb_write & (paddr_in == RELEASE_ADDR) & data_present;
    always_comb begin
        next_evt_count = evt_count;
        if (evt_store && !evt_release) begin
            next_evt_count = evt_count + 1'b1;
        end else if (evt_release && !evt_store) begin
            next_evt_count = evt_count - 1'b1;
        end
        if (reset_edge) begin
            next_evt_count = '0;
        end
        if (!clk_en_in) begin
            next_evt_count = evt_count;
        end
    end

    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            state            <= CONV_IDLE;
            timer            <= '0;
            faw_count        <= '0;
            inhibit_seen     <= 1'b0;
            evt_count        <= '0;
            peak_clear_out   <= 1'b0;
            event_stored_out <= 1'b0;
        end else begin
            state            <= next_state;
            timer            <= next_timer;
            faw_count        <= next_faw_count;
            inhibit_seen     <= next_inhibit_seen;
            evt_count        <= next_evt_count;
            peak_clear_out   <= next_peak_clear;
            event_stored_out <= evt_store;
        end
    end

    // ------------------------------------------------------------
    // Shared line drivers
    // ------------------------------------------------------------
    // Positive line: drive high when set; negative: drive high when clear,
    // so the wire falls only when every module is set.
    always_ff @(posedge core_clk_in or posedge reset_in) begin
        if (reset_in) begin
            data_present_wired_or_out      <= 1'b1;
            data_present_wired_or_oe_out   <= 1'b0;
            data_present_wired_nand_out    <= 1'b1;
            data_present_wired_nand_oe_out <= 1'b1;
            busy_wired_or_out              <= 1'b1;
            busy_wired_or_oe_out           <= 1'b0;
            busy_wired_nand_out            <= 1'b1;
            busy_wired_nand_oe_out         <= 1'b1;
        end else if (clk_en_in) begin
            data_present_wired_or_oe_out   <= data_present;
            data_present_wired_nand_oe_out <= ~data_present;
            busy_wired_or_oe_out           <= busy;
            busy_wired_nand_oe_out         <= ~busy;
        end
    end

endmodule // front_panel_control

`default_nettype wire

// ---- verilog/front_panel_pkg.sv ----
package front_panel_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS    = 100;
    localparam int CONV_TIME_NS     = 2800;
    localparam int CONV_CYCLES      = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ABORT_GAP_NS     = 600;
    localparam int ABORT_GAP_CYCLES = (ABORT_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W            = 8;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] STATUS1_ADDR   = 8'h00;
    localparam logic [ADDR_W-1:0] CONTROL1_ADDR  = 8'h04;
    localparam logic [ADDR_W-1:0] ABORT_WIN_ADDR = 8'h08;
    localparam logic [ADDR_W-1:0] RELEASE_ADDR   = 8'h0c;
    localparam logic [ADDR_W-1:0] EVT_COUNT_ADDR = 8'h10;

    // Status 1 bits
    localparam int ST_DATA_PRESENT = 0;
    localparam int ST_DP_LINE      = 1;
    localparam int ST_BUSY         = 2;
    localparam int ST_BUSY_LINE    = 3;

    // Control 1 bits
    localparam int CR_MEM_TEST     = 0;
    localparam int CR_RESET_SCOPE  = 4;
    localparam int CR_W            = 5;

    localparam logic [CR_W-1:0]  CONTROL1_RESET  = 5'h00;
    localparam logic [CNT_W-1:0] ABORT_WIN_RESET = 8'h10;

    // ------------------------------------------------------------
    // Event buffer occupancy
    // ------------------------------------------------------------
    localparam int EVT_W = 6;
    localparam logic [EVT_W-1:0] EVT_DEPTH = 6'h20;

    // ------------------------------------------------------------
    // Synchronised front-panel inputs
    // ------------------------------------------------------------
    localparam int IN_ACQ       = 0;
    localparam int IN_COMMON    = 1;
    localparam int IN_INHIBIT   = 2;
    localparam int IN_ABORT     = 3;
    localparam int IN_RESET     = 4;
    localparam int IN_DP_LINE   = 5;
    localparam int IN_BUSY_LINE = 6;
    localparam int N_IN         = 7;

    typedef enum logic [1:0] {
        CONV_IDLE,
        CONV_RUN,
        CONV_CLEAR
    } conv_state_t;

endpackage
